// ==== rtl/ooc_params.svh ====
// ooc_params.svh: constants of the output on/off and margin control
// Overview of operation
// - enable 00: output off at once
// - enable 01: soft off with sequencing
// - enable 10: output on at margin state
// - margin 00 nominal, 01 low, 10 high
// - fault field 01 ignore, 10 act when margined
// - powerup bit 0: run whenever power present
// - powerup bit 1: off until sources command on
// - bus mode 0: ignore operation on/off
// - bus mode 1: operation must command run
// - pin mode: ignore pin or require it
// - pin polarity: 0 low active, 1 high
// - pin fast bit 0: pin off uses sequencing
// - pin fast bit 1: pin off immediate
`ifndef OOC_PARAMS_SVH
`define OOC_PARAMS_SVH

// command codes
`define OOC_CMD_OPERATION    8'h01
`define OOC_CMD_ON_OFF_CFG   8'h02
`define OOC_CMD_CLEAR_FAULTS 8'h03
`define OOC_CMD_RUN_STATUS   8'hD8
`define OOC_RD_UNMAPPED      8'h00

// reset values
`define OOC_OPER_RST 8'h80
`define OOC_CFG_RST  8'h1A
`define OOC_CFG_MASK 8'h1F

// run_and_margin_control fields
`define OOC_OP_EN_MSB  7
`define OOC_OP_EN_LSB  6
`define OOC_OP_MRG_MSB 5
`define OOC_OP_MRG_LSB 4
`define OOC_OP_FLT_MSB 3
`define OOC_OP_FLT_LSB 2
`define OOC_EN_IMM_OFF  2'h0
`define OOC_EN_SOFT_OFF 2'h1
`define OOC_EN_ON       2'h2
`define OOC_FLD_BAD     2'h3
`define OOC_MRG_NOM     2'h0
`define OOC_MRG_LOW     2'h1
`define OOC_MRG_HIGH    2'h2
`define OOC_FLT_IGNORE  2'h1
`define OOC_FLT_ACT     2'h2

// on_off_source_config bits
`define OOC_CFG_PWRUP_BIT 4
`define OOC_CFG_BUS_BIT   3
`define OOC_CFG_PIN_BIT   2
`define OOC_CFG_POL_BIT   1
`define OOC_CFG_FAST_BIT  0

// timing
`define OOC_MCLK_MHZ    100
`define OOC_TOFF_DLY_NS 2000
`define OOC_TFALL_NS    4000

`endif

// ==== rtl/ooc_pkg.sv ====
// ooc_pkg.sv: types of the output on/off and margin control
package ooc_pkg;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_ON,
		ST_OFF_DLY,
		ST_FALL
	} ooc_run_st_t;

	typedef struct packed {
		logic       rd;
		logic [7:0] code;
		logic [7:0] data;
	} ooc_req_t;

	typedef struct packed {
		logic       pwr_en;
		logic       ramp_dn;
		logic       fast_stop;
		logic [1:0] margin;
		logic       flt_ignore;
	} ooc_drive_t;

	typedef struct packed {
		logic [1:0]  pin_sync;
		logic [1:0]  pwr_sync;
		logic [1:0]  req_sync;
		logic        ack_tgl;
		logic [7:0]  rsp;
		logic [7:0]  oper;
		logic [7:0]  cfg;
		logic        bad_wr;
		ooc_run_st_t st;
		logic [15:0] cnt;
		ooc_drive_t  drv;
	} ooc_core_st_t;

	typedef struct packed {
		logic [1:0] ack_sync;
		logic       req_tgl;
		logic       busy;
		logic       done;
		ooc_req_t   req;
		logic [7:0] rdata;
	} ooc_link_st_t;

endpackage

// ==== rtl/ooc_link_port.sv ====
// ooc_link_port.sv: link-clock side of the command port
`timescale 1ns/1ns
`default_nettype none

module ooc_link_port (
	input  wire logic             lnk_clk_i,
	input  wire logic             lnk_rstn_i,
	input  wire logic             lnk_wr_i,
	input  wire logic             lnk_rd_i,
	input  wire logic [7:0]       lnk_code_i,
	input  wire logic [7:0]       lnk_wdata_i,
	output logic                  lnk_busy_o,
	output logic                  lnk_done_o,
	output logic [7:0]            lnk_rdata_o,
	output ooc_pkg::ooc_req_t     req_o,
	output logic                  req_tgl_o,
	input  wire logic             ack_tgl_i,
	input  wire logic [7:0]       rsp_i
);

	ooc_pkg::ooc_link_st_t q;
	ooc_pkg::ooc_link_st_t n;

	// ------------------------------------------------------------
	// request / answer handshake
	// ------------------------------------------------------------
	always_comb begin
		n          = q;
		n.done     = 1'b0;
		n.ack_sync = {q.ack_sync[0], ack_tgl_i};
		if (q.busy && (q.ack_sync[1] == q.req_tgl)) begin
			// answer word is stable once the ack toggle arrived
			n.busy = 1'b0;
			n.done = 1'b1;
			if (q.req.rd) begin
				n.rdata = rsp_i;
			end
		end else if (!q.busy && (lnk_wr_i || lnk_rd_i)) begin
			// write wins when both strobes are high
			n.req.rd   = ~lnk_wr_i;
			n.req.code = lnk_code_i;
			n.req.data = lnk_wdata_i;
			n.req_tgl  = ~q.req_tgl;
			n.busy     = 1'b1;
		end
	end

	always_ff @(posedge lnk_clk_i) begin
		if (!lnk_rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign lnk_busy_o  = q.busy;
	assign lnk_done_o  = q.done;
	assign lnk_rdata_o = q.rdata;
	assign req_o       = q.req;
	assign req_tgl_o   = q.req_tgl;

endmodule

`default_nettype wire

// ==== rtl/ooc_output_ctrl.sv ====
// ooc_output_ctrl.sv: output on/off sequencing and margin control
`include "ooc_params.svh"
`timescale 1ns/1ns
`default_nettype none

module ooc_output_ctrl #(
	parameter int unsigned MCLK_MHZ    = `OOC_MCLK_MHZ,
	parameter int unsigned TOFF_DLY_NS = `OOC_TOFF_DLY_NS,
	parameter int unsigned TFALL_NS    = `OOC_TFALL_NS
) (
	input  wire logic       mclk_i,
	input  wire logic       rstn_i,
	input  wire logic       lnk_clk_i,
	input  wire logic       lnk_rstn_i,
	input  wire logic       lnk_wr_i,
	input  wire logic       lnk_rd_i,
	input  wire logic [7:0] lnk_code_i,
	input  wire logic [7:0] lnk_wdata_i,
	input  wire logic       ctl_pin_i,
	input  wire logic       pwr_ok_i,
	output logic            lnk_busy_o,
	output logic            lnk_done_o,
	output logic [7:0]      lnk_rdata_o,
	output logic            pwr_en_o,
	output logic            ramp_dn_o,
	output logic            fast_stop_o,
	output logic [1:0]      margin_o,
	output logic            flt_ignore_o
);

	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	// delays round up to whole cycles and never drop below one cycle
	localparam int unsigned DLY_RAW  = (TOFF_DLY_NS * MCLK_MHZ + 999) / 1000;
	localparam int unsigned FALL_RAW = (TFALL_NS * MCLK_MHZ + 999) / 1000;
	localparam int unsigned DLY_CYC  = (DLY_RAW < 1) ? 1 : DLY_RAW;
	localparam int unsigned FALL_CYC = (FALL_RAW < 1) ? 1 : FALL_RAW;
	localparam logic [15:0] DLY_LD   = 16'(DLY_CYC - 1);
	localparam logic [15:0] FALL_LD  = 16'(FALL_CYC - 1);

	if (DLY_CYC > 65536 || FALL_CYC > 65536) begin : g_cnt_chk
		$error("turn-off delay or fall time exceeds the 16-bit counter");
	end
	if (MCLK_MHZ == 0) begin : g_clk_chk
		$error("clock rate must be nonzero");
	end
	if ((`OOC_OP_EN_MSB - `OOC_OP_EN_LSB) != 1
		|| (`OOC_OP_MRG_MSB - `OOC_OP_MRG_LSB) != 1
		|| (`OOC_OP_FLT_MSB - `OOC_OP_FLT_LSB) != 1) begin : g_fld_chk
		$error("operation fields must each be two bits wide");
	end
	if ((`OOC_OP_EN_LSB <= `OOC_OP_MRG_MSB) || (`OOC_OP_MRG_LSB <= `OOC_OP_FLT_MSB)) begin : g_ord_chk
		$error("operation fields must not overlap");
	end
	if (`OOC_CFG_PWRUP_BIT > 7 || `OOC_CFG_FAST_BIT > 7) begin : g_cfg_chk
		$error("config bit positions must lie in one byte");
	end

	// after reset the output is off and both registers hold their defaults
	localparam ooc_pkg::ooc_core_st_t CORE_RST = '{
		pin_sync: 2'h0,
		pwr_sync: 2'h0,
		req_sync: 2'h0,
		ack_tgl:  1'b0,
		rsp:      8'h00,
		oper:     `OOC_OPER_RST,
		cfg:      `OOC_CFG_RST,
		bad_wr:   1'b0,
		st:       ooc_pkg::ST_OFF,
		cnt:      16'h0000,
		drv:      '{
			pwr_en:     1'b0,
			ramp_dn:    1'b0,
			fast_stop:  1'b0,
			margin:     `OOC_MRG_NOM,
			flt_ignore: 1'b0
		}
	};

	// ------------------------------------------------------------
	// link-clock command port
	// ------------------------------------------------------------
	ooc_pkg::ooc_req_t     lnk_req;
	logic                  lnk_req_tgl;
	ooc_pkg::ooc_core_st_t q;
	ooc_pkg::ooc_core_st_t n;

	// only the toggle crosses through flip-flops; the request word is held until answered
	ooc_link_port i_ooc_link_port (
		.lnk_clk_i   (lnk_clk_i),
		.lnk_rstn_i  (lnk_rstn_i),
		.lnk_wr_i    (lnk_wr_i),
		.lnk_rd_i    (lnk_rd_i),
		.lnk_code_i  (lnk_code_i),
		.lnk_wdata_i (lnk_wdata_i),
		.lnk_busy_o  (lnk_busy_o),
		.lnk_done_o  (lnk_done_o),
		.lnk_rdata_o (lnk_rdata_o),
		.req_o       (lnk_req),
		.req_tgl_o   (lnk_req_tgl),
		.ack_tgl_i   (q.ack_tgl),
		.rsp_i       (q.rsp)
	);

	// ------------------------------------------------------------
	// refused field codes of an operation write
	// ------------------------------------------------------------
	localparam int unsigned FLD_LSB [3] = '{`OOC_OP_FLT_LSB, `OOC_OP_MRG_LSB, `OOC_OP_EN_LSB};

	logic [2:0] fld_bad;

	for (genvar f = 0; f < 3; f++) begin : g_fld
		assign fld_bad[f] = (lnk_req.data[FLD_LSB[f] +: 2] == `OOC_FLD_BAD);
	end

	// ------------------------------------------------------------
	// decoded fields and run decision
	// ------------------------------------------------------------
	logic [1:0] op_en;
	logic [1:0] op_mrg;
	logic [1:0] op_flt;
	logic       pin_s;
	logic       pwr_s;
	logic       pin_act;
	logic       cfg_pwrup;
	logic       cfg_bus;
	logic       cfg_pin;
	logic       cfg_pol;
	logic       cfg_fast;
	logic       bus_ok;
	logic       pin_ok;
	logic       want_on;
	logic       bus_imm;
	logic       pin_imm;
	logic       imm_off;
	logic       wr_bad;
	logic       take;
	logic [7:0] status;

	always_comb begin
		op_en     = q.oper[`OOC_OP_EN_MSB:`OOC_OP_EN_LSB];
		op_mrg    = q.oper[`OOC_OP_MRG_MSB:`OOC_OP_MRG_LSB];
		op_flt    = q.oper[`OOC_OP_FLT_MSB:`OOC_OP_FLT_LSB];
		pin_s     = q.pin_sync[1];
		pwr_s     = q.pwr_sync[1];
		cfg_pwrup = q.cfg[`OOC_CFG_PWRUP_BIT];
		cfg_bus   = q.cfg[`OOC_CFG_BUS_BIT];
		cfg_pin   = q.cfg[`OOC_CFG_PIN_BIT];
		cfg_pol   = q.cfg[`OOC_CFG_POL_BIT];
		cfg_fast  = q.cfg[`OOC_CFG_FAST_BIT];

		// pin level that means enable
		pin_act = cfg_pol ? pin_s : ~pin_s;

		// bus source, ignored when bus mode is off
		bus_ok = ~cfg_bus | (op_en == `OOC_EN_ON);

		// pin source, ignored when pin mode is off
		pin_ok = ~cfg_pin | pin_act;

		// with powerup bit clear the sources are not consulted
		if (!cfg_pwrup) begin
			want_on = pwr_s;
		end else begin
			want_on = pwr_s & (cfg_bus | cfg_pin) & bus_ok & pin_ok;
		end

		// kinds of off that skip sequencing
		bus_imm = cfg_pwrup & cfg_bus & (op_en == `OOC_EN_IMM_OFF);
		pin_imm = cfg_pwrup & cfg_pin & ~pin_act & cfg_fast;
		imm_off = ~pwr_s | bus_imm | pin_imm;

		// a new request is pending when the toggles differ
		take = (q.req_sync[1] != q.ack_tgl);

		// any field coded 11 spoils the whole write
		wr_bad = |fld_bad;

		// status byte: state, power enable, pin asserted, power good, refused write
		status = {2'h0, q.st, q.drv.pwr_en, pin_act, pwr_s, q.bad_wr};
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		n          = q;

		// ------------------------------------------------------------
		// pin, power and request synchronisers
		// ------------------------------------------------------------
		n.pin_sync = {q.pin_sync[0], ctl_pin_i};
		n.pwr_sync = {q.pwr_sync[0], pwr_ok_i};
		n.req_sync = {q.req_sync[0], lnk_req_tgl};

		// ------------------------------------------------------------
		// command execution
		// ------------------------------------------------------------
		// request fields are held by the link side until acked
		if (take) begin
			n.ack_tgl = q.req_sync[1];
			if (lnk_req.rd) begin
				unique case (lnk_req.code)
					`OOC_CMD_OPERATION: begin
						n.rsp = q.oper;
					end
					`OOC_CMD_ON_OFF_CFG: begin
						n.rsp = q.cfg;
					end
					`OOC_CMD_RUN_STATUS: begin
						n.rsp = status;
					end
					default: begin
						n.rsp = `OOC_RD_UNMAPPED;
					end
				endcase
			end else begin
				unique case (lnk_req.code)
					`OOC_CMD_OPERATION: begin
						if (wr_bad) begin
							n.bad_wr = 1'b1;
						end else begin
							n.oper = {lnk_req.data[7:2], 2'h0};
						end
					end
					`OOC_CMD_ON_OFF_CFG: begin
						n.cfg = lnk_req.data & `OOC_CFG_MASK;
					end
					`OOC_CMD_CLEAR_FAULTS: begin
						n.bad_wr = 1'b0;
					end
					default: begin
						n.bad_wr = q.bad_wr;
					end
				endcase
			end
		end

		// ------------------------------------------------------------
		// output sequencing
		// ------------------------------------------------------------
		unique case (q.st)
			ooc_pkg::ST_OFF: begin
				if (want_on && !imm_off) begin
					n.st = ooc_pkg::ST_ON;
				end
			end
			ooc_pkg::ST_ON: begin
				if (imm_off) begin
					n.st = ooc_pkg::ST_OFF;
				end else if (!want_on) begin
					n.st  = ooc_pkg::ST_OFF_DLY;
					n.cnt = DLY_LD;
				end
			end
			ooc_pkg::ST_OFF_DLY: begin
				// a returning run request cancels the turn-off
				if (imm_off) begin
					n.st = ooc_pkg::ST_OFF;
				end else if (want_on) begin
					n.st = ooc_pkg::ST_ON;
				end else if (q.cnt == 16'h0000) begin
					n.st  = ooc_pkg::ST_FALL;
					n.cnt = FALL_LD;
				end else begin
					n.cnt = q.cnt - 16'h0001;
				end
			end
			ooc_pkg::ST_FALL: begin
				if (imm_off) begin
					n.st = ooc_pkg::ST_OFF;
				end else if (want_on) begin
					n.st = ooc_pkg::ST_ON;
				end else if (q.cnt == 16'h0000) begin
					n.st = ooc_pkg::ST_OFF;
				end else begin
					n.cnt = q.cnt - 16'h0001;
				end
			end
		endcase

		// ------------------------------------------------------------
		// drive toward the power stage
		// ------------------------------------------------------------
		n.drv.pwr_en  = (n.st != ooc_pkg::ST_OFF);
		n.drv.ramp_dn = (n.st == ooc_pkg::ST_FALL);
		// fast stop stays up until the next turn-on, so the kind of off can be seen
		if (n.st == ooc_pkg::ST_ON) begin
			n.drv.fast_stop = 1'b0;
		end else if (imm_off && q.st != ooc_pkg::ST_OFF) begin
			n.drv.fast_stop = 1'b1;
		end

		// ------------------------------------------------------------
		// margin and fault handling
		// ------------------------------------------------------------
		// margin setpoint only while regulating
		if (n.st == ooc_pkg::ST_ON) begin
			n.drv.margin = op_mrg;
		end else begin
			n.drv.margin = `OOC_MRG_NOM;
		end

		// OV/UV handling is only relaxed while margined
		n.drv.flt_ignore = (n.drv.margin != `OOC_MRG_NOM)
			& (op_flt == `OOC_FLT_IGNORE);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// synchronous reset also flushes all three synchroniser chains
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			q <= CORE_RST;
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign pwr_en_o     = q.drv.pwr_en;
	assign ramp_dn_o    = q.drv.ramp_dn;
	assign fast_stop_o  = q.drv.fast_stop;
	assign margin_o     = q.drv.margin;
	assign flt_ignore_o = q.drv.flt_ignore;

endmodule

`default_nettype wire

// ==== bench/ooc_output_ctrl_asserts.sv ====
// port checker for the output on/off control
`timescale 1ns/1ns
`default_nettype none
module ooc_output_ctrl_asserts (
	input wire logic       mclk_i,
	input wire logic       rstn_i,
	input wire logic       lnk_clk_i,
	input wire logic       lnk_rstn_i,
	input wire logic       pwr_ok_i,
	input wire logic       lnk_busy_o,
	input wire logic       lnk_done_o,
	input wire logic       pwr_en_o,
	input wire logic       ramp_dn_o,
	input wire logic       fast_stop_o,
	input wire logic [1:0] margin_o,
	input wire logic       flt_ignore_o
);
	AST_FAST_OFF: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		fast_stop_o |-> !pwr_en_o) else $error("fast stop with power on");
	AST_SOFT_PATH: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$fell(pwr_en_o) |-> fast_stop_o || $past(ramp_dn_o)) else $error("soft off skipped fall");
	AST_RAMP_ON: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ramp_dn_o |-> pwr_en_o) else $error("fall phase without power");
	AST_NOM_OFF: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!pwr_en_o |-> margin_o == 2'h0 && !flt_ignore_o) else $error("margin while off");
	AST_MRG_CODE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		margin_o != 2'h3) else $error("invalid margin code");
	AST_FLT_MRG: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		flt_ignore_o |-> margin_o != 2'h0) else $error("fault ignore at nominal");
	AST_PWR_LOSS: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!pwr_ok_i [*4] |=> !pwr_en_o) else $error("power on without input");
	AST_PWR_REQ: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$rose(pwr_en_o) |-> $past(pwr_ok_i, 3)) else $error("start without input");
	AST_DONE_PULSE: assert property (@(posedge lnk_clk_i) disable iff (!lnk_rstn_i)
		lnk_done_o |=> !lnk_done_o) else $error("done longer than one cycle");
	AST_DONE_IDLE: assert property (@(posedge lnk_clk_i) disable iff (!lnk_rstn_i)
		lnk_done_o |-> !lnk_busy_o) else $error("busy during done");
endmodule
bind ooc_output_ctrl ooc_output_ctrl_asserts i_ooc_output_ctrl_asserts (
	.mclk_i, .rstn_i, .lnk_clk_i, .lnk_rstn_i, .pwr_ok_i, .lnk_busy_o,
	.lnk_done_o, .pwr_en_o, .ramp_dn_o, .fast_stop_o, .margin_o, .flt_ignore_o
);
`default_nettype wire

// ==== bench/ooc_host_model.sv ====
// host and remote pin driver model
`timescale 1ns/1ns
`default_nettype none
module ooc_host_model (
	input  wire logic       lnk_clk_i,
	input  wire logic       lnk_busy_i,
	input  wire logic       lnk_done_i,
	input  wire logic [7:0] lnk_rdata_i,
	input  wire logic       pin_on_i,
	input  wire logic       pin_pol_i,
	output logic            lnk_wr_o,
	output logic            lnk_rd_o,
	output logic [7:0]      lnk_code_o,
	output logic [7:0]      lnk_wdata_o,
	output logic            ctl_pin_o
);
	assign ctl_pin_o = pin_pol_i ? pin_on_i : !pin_on_i;
	initial begin
		lnk_wr_o = 1'b0;
		lnk_rd_o = 1'b0;
		lnk_code_o = 8'h00;
		lnk_wdata_o = 8'h00;
	end
	// strobe held until the edge that takes it while idle, answer taken at done
	task automatic xfer(input logic rd, input logic [7:0] c, input logic [7:0] d, output logic [7:0] q,
		output logic ok);
		int n;
		n = 0;
		@(posedge lnk_clk_i);
		lnk_wr_o <= !rd;
		lnk_rd_o <= rd;
		lnk_code_o <= c;
		lnk_wdata_o <= d;
		@(posedge lnk_clk_i);
		while (lnk_busy_i !== 1'b0 && n < 40) begin
			@(posedge lnk_clk_i);
			n++;
		end
		lnk_wr_o <= 1'b0;
		lnk_rd_o <= 1'b0;
		lnk_wdata_o <= ~d;
		while (lnk_done_i !== 1'b1 && n < 40) begin
			@(posedge lnk_clk_i);
			n++;
		end
		q = lnk_rdata_i;
		ok = (n < 40);
	endtask
endmodule
`default_nettype wire

// ==== bench/ooc_output_ctrl_bench.sv ====
// self-checking bench for the output on/off control
`timescale 1ns/1ns
`default_nettype none
module ooc_output_ctrl_bench;
	logic       mclk = 1'b0;
	logic       lclk = 1'b0;
	logic       rstn = 1'b0;
	logic       lrstn = 1'b0;
	logic       pwr_ok = 1'b1;
	logic       pon = 1'b0;
	logic       ppol = 1'b1;
	logic       wr, rd, busy, done, pin, pwr_en, ramp, fast, flt;
	logic [7:0] code, wdata, rdata, q;
	logic [1:0] mrg;
	logic [7:0] ops [3] = '{8'h80, 8'h94, 8'hA8};
	logic [7:0] bad [3] = '{8'hC0, 8'hB8, 8'hAC};
	int         miscompares = 0;
	int         samples_checked = 0;
	always #5 mclk = ~mclk;
	always begin
		#7 lclk = ~lclk;
		#8 lclk = ~lclk;
	end
	ooc_output_ctrl #(.TOFF_DLY_NS(50), .TFALL_NS(80)) i_ooc_output_ctrl (
		.mclk_i(mclk), .rstn_i(rstn), .lnk_clk_i(lclk), .lnk_rstn_i(lrstn),
		.lnk_wr_i(wr), .lnk_rd_i(rd), .lnk_code_i(code), .lnk_wdata_i(wdata),
		.ctl_pin_i(pin), .pwr_ok_i(pwr_ok), .lnk_busy_o(busy), .lnk_done_o(done),
		.lnk_rdata_o(rdata), .pwr_en_o(pwr_en), .ramp_dn_o(ramp), .fast_stop_o(fast),
		.margin_o(mrg), .flt_ignore_o(flt)
	);
	ooc_host_model i_ooc_host_model (
		.lnk_clk_i(lclk), .lnk_busy_i(busy), .lnk_done_i(done), .lnk_rdata_i(rdata), .pin_on_i(pon),
		.pin_pol_i(ppol), .lnk_wr_o(wr), .lnk_rd_o(rd), .lnk_code_o(code),
		.lnk_wdata_o(wdata), .ctl_pin_o(pin)
	);
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic w(input logic [7:0] c, input logic [7:0] d);
		logic ok;
		i_ooc_host_model.xfer(1'b0, c, d, q, ok);
		chk("lnk_done", 8'h01, {7'h00, ok});
	endtask
	task automatic r(input logic [7:0] c, input logic [7:0] e);
		logic ok;
		i_ooc_host_model.xfer(1'b1, c, 8'h00, q, ok);
		chk("lnk_done", 8'h01, {7'h00, ok});
		chk("rdata", e, q);
	endtask
	// bounded wait for the power enable level
	task automatic wp(input logic e, input int n);
		for (int i = 0; i < n && pwr_en !== e; i++) @(posedge mclk);
		chk("pwr_en", {7'h00, e}, {7'h00, pwr_en});
	endtask
	task automatic pn(input logic on, input logic pol);
		@(posedge mclk);
		pon <= on;
		ppol <= pol;
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge lclk);
		lrstn <= 1'b1;
		r(8'h01, 8'h80);
		r(8'h02, 8'h1A);
		r(8'h55, 8'h00);
		wp(1'b1, 20);
		foreach (ops[i]) begin
			w(8'h01, ops[i]);
			chk("margin", {6'h00, ops[i][5:4]}, {6'h00, mrg});
			chk("flt_ignore", {7'h00, ops[i][3:2] == 2'h1}, {7'h00, flt});
		end
		foreach (bad[i]) begin
			w(8'h01, bad[i]);
			r(8'h01, 8'hA8);
		end
		r(8'hD8, 8'h1B);
		w(8'h03, 8'h00);
		r(8'hD8, 8'h1A);
		w(8'h01, 8'h40);
		chk("soft hold", 8'h01, {7'h00, pwr_en});
		for (int i = 0; i < 20 && ramp !== 1'b1; i++) @(posedge mclk);
		chk("ramp_dn", 8'h01, {7'h00, ramp});
		wp(1'b0, 30);
		chk("fast_stop", 8'h00, {7'h00, fast});
		w(8'h01, 8'h80);
		wp(1'b1, 20);
		w(8'h01, 8'h00);
		wp(1'b0, 4);
		chk("fast_stop", 8'h01, {7'h00, fast});
		w(8'h02, 8'h16);
		pn(1'b1, 1'b1);
		wp(1'b1, 20);
		pn(1'b0, 1'b1);
		wp(1'b0, 30);
		chk("fast_stop", 8'h00, {7'h00, fast});
		pn(1'b1, 1'b1);
		wp(1'b1, 20);
		w(8'h02, 8'h17);
		pn(1'b0, 1'b1);
		wp(1'b0, 6);
		chk("fast_stop", 8'h01, {7'h00, fast});
		w(8'h02, 8'h14);
		pn(1'b1, 1'b0);
		wp(1'b1, 20);
		w(8'h02, 8'h04);
		pn(1'b0, 1'b0);
		repeat (20) @(posedge mclk);
		wp(1'b1, 1);
		@(posedge mclk) pwr_ok <= 1'b0;
		wp(1'b0, 8);
		@(posedge mclk) pwr_ok <= 1'b1;
		wp(1'b1, 8);
		@(posedge mclk) pwr_ok <= 1'b0;
		wp(1'b0, 8);
		w(8'h02, 8'h1A);
		@(posedge mclk) pwr_ok <= 1'b1;
		repeat (20) @(posedge mclk);
		wp(1'b0, 1);
		complete_run;
	end
endmodule
`default_nettype wire
